// File: sync_pin_and_common_regs.sv
// Sync pin logic and common register bank of the rate sensor
`timescale 1ns/1ns
module sync_pin_and_common_regs #(
	parameter logic [7:0] IDENTITY_CODE = 8'h5a, // Arbitrary value
	parameter int         FIFO_DEPTH    = 256
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Sync pin
	input  wire logic        sync_pin,
	// Host register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// Sensor core samples
	input  wire logic        sample_valid,
	input  wire logic [15:0] rate_x,
	input  wire logic [15:0] rate_z,
	input  wire logic [15:0] temperature,
	input  wire logic        endian_swap,
	input  wire logic        parity_error_set,
	// Status towards the core
	output logic      [1:0]  power_state,
	output logic             parity_error,
	output logic             highpass_clear
);
	// ------------------------------------------------------------
	// Reset release and pin synchroniser
	// ------------------------------------------------------------
	// Pointers wrap by overflow, so the depth must be a power of two
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256
		|| (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_bad
		$error("FIFO_DEPTH out of range");
	end
	localparam int AW = $clog2(FIFO_DEPTH);
	logic [1:0] rst_q;
	logic       rst_n;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_q <= 2'b00;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];
	logic sync_meta_q, sync_lvl_q, sync_prev_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_meta_q <= 1'b0;
			sync_lvl_q  <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			sync_meta_q <= sync_pin;
			sync_lvl_q  <= sync_meta_q;
			sync_prev_q <= sync_lvl_q;
		end
	end
	// ------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------
	logic [7:0] power_cfg_q, sense_cfg1_q, ready_cfg_q;
	logic [7:0] sync_cfg_q, sync_cnt_q;
	logic [3:0] bank_q;
	logic       wr_bank0, wr_common;
	assign wr_common = reg_wr && reg_addr[sync_regs_pkg::COMMON_BIT];
	assign wr_bank0  = reg_wr && !reg_addr[sync_regs_pkg::COMMON_BIT]
		&& bank_q == sync_regs_pkg::BANK_ZERO;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_cfg_q  <= sync_regs_pkg::RST_POWER_CFG;
			sense_cfg1_q <= sync_regs_pkg::RST_SENSE_CFG1;
			ready_cfg_q  <= sync_regs_pkg::RST_READY_CFG;
			sync_cfg_q   <= sync_regs_pkg::RST_ZERO;
			sync_cnt_q   <= sync_regs_pkg::RST_ZERO;
			bank_q       <= sync_regs_pkg::BANK_ZERO;
		end else begin
			if (wr_common && reg_addr == sync_regs_pkg::OFS_BANK_SEL)
				bank_q <= reg_wdata[3:0];
			if (wr_bank0) begin
				case (reg_addr)
				sync_regs_pkg::OFS_POWER_CFG:  power_cfg_q  <= reg_wdata;
				sync_regs_pkg::OFS_SENSE_CFG1: sense_cfg1_q <= reg_wdata;
				sync_regs_pkg::OFS_READY_CFG:  ready_cfg_q  <= reg_wdata;
				sync_regs_pkg::OFS_SYNC_CFG:   sync_cfg_q   <= reg_wdata;
				sync_regs_pkg::OFS_SYNC_CNT:   sync_cnt_q   <= reg_wdata;
				default: ;
				endcase
			end
		end
	end
	// ------------------------------------------------------------
	// Wake condition and power state
	// ------------------------------------------------------------
	logic pin_act, pin_rise, pin_fall, wake_hit, trig_edge;
	logic wake_q;
	assign pin_act  = sync_lvl_q ^ sync_cfg_q[sync_regs_pkg::F_POL_LOW];
	assign pin_rise = sync_lvl_q && !sync_prev_q;
	assign pin_fall = !sync_lvl_q && sync_prev_q;
	assign trig_edge = sync_cfg_q[sync_regs_pkg::F_POL_LOW] ? pin_fall : pin_rise;
	// Edge mode latches wake on the active edge and sleep on the other
	assign wake_hit = sync_cfg_q[sync_regs_pkg::F_TRIG_EDGE] ?
		(trig_edge ? 1'b1 : ((pin_rise || pin_fall) ? 1'b0 : wake_q))
		: pin_act;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wake_q <= 1'b0;
		else
			wake_q <= wake_hit;
	end
	sync_regs_pkg::power_state_t pwr_d, pwr_q;
	always_comb begin
		case (power_cfg_q[sync_regs_pkg::F_PWR_HI:sync_regs_pkg::F_PWR_LO])
		sync_regs_pkg::PM_DOWN:    pwr_d = sync_regs_pkg::PWR_DOWN;
		sync_regs_pkg::PM_NORMAL:  pwr_d = sync_regs_pkg::PWR_NORMAL;
		sync_regs_pkg::PM_STANDBY: pwr_d = sync_regs_pkg::PWR_STANDBY;
		sync_regs_pkg::PM_ECO:     pwr_d = sync_regs_pkg::PWR_ECO;
		sync_regs_pkg::PM_SB_ECO:  pwr_d = wake_q ? sync_regs_pkg::PWR_ECO
			: sync_regs_pkg::PWR_STANDBY;
		sync_regs_pkg::PM_PD_ECO:  pwr_d = wake_q ? sync_regs_pkg::PWR_ECO
			: sync_regs_pkg::PWR_DOWN;
		sync_regs_pkg::PM_SB_NORM: pwr_d = wake_q ? sync_regs_pkg::PWR_NORMAL
			: sync_regs_pkg::PWR_STANDBY;
		sync_regs_pkg::PM_PD_NORM: pwr_d = wake_q ? sync_regs_pkg::PWR_NORMAL
			: sync_regs_pkg::PWR_DOWN;
		default:                   pwr_d = sync_regs_pkg::PWR_DOWN;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pwr_q <= sync_regs_pkg::PWR_DOWN;
		else
			pwr_q <= pwr_d;
	end
	assign power_state = pwr_q;
	// ------------------------------------------------------------
	// Sample path with LSb mapping
	// ------------------------------------------------------------
	logic [15:0] x_q, z_q, t_q, x_m, z_m, t_m;
	logic        map_rate, map_temp;
	// Mapping samples the pin level, never an edge
	assign map_rate = sync_cfg_q[sync_regs_pkg::F_RATE_MAP];
	assign map_temp = sync_cfg_q[sync_regs_pkg::F_TEMP_MAP];
	assign x_m = map_rate ? {rate_x[15:1], sync_lvl_q} : rate_x;
	assign z_m = map_rate ? {rate_z[15:1], sync_lvl_q} : rate_z;
	assign t_m = map_temp ? {temperature[15:1], sync_lvl_q}
		: temperature;
	logic en_x, en_z;
	assign en_x = power_cfg_q[sync_regs_pkg::F_EN_X];
	assign en_z = power_cfg_q[sync_regs_pkg::F_EN_Z];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			x_q <= 16'h0000;
			z_q <= 16'h0000;
			t_q <= 16'h0000;
		end else if (sample_valid) begin
			x_q <= x_m;
			z_q <= z_m;
			t_q <= t_m;
		end
	end
	// ------------------------------------------------------------
	// Ready and overrun flags
	// ------------------------------------------------------------
	logic rdy_q, err_q, data_rd, rdy_clear;
	assign data_rd = reg_rd && reg_addr >= sync_regs_pkg::OFS_X_HIGH
		&& reg_addr <= sync_regs_pkg::OFS_T_LOW;
	// Clear on any data read, or only on status read
	assign rdy_clear = ready_cfg_q[sync_regs_pkg::F_RDY_ON_READ] ? data_rd
		: (reg_rd && reg_addr == sync_regs_pkg::OFS_SYS_FLAGS);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			// Set wins over the clear
			if (sample_valid)
				rdy_q <= 1'b1;
			else if (rdy_clear)
				rdy_q <= 1'b0;
			if (sample_valid && (rdy_q || data_rd))
				err_q <= 1'b1;
			else if (reg_rd && reg_addr == sync_regs_pkg::OFS_SYS_FLAGS)
				err_q <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Sync triggered capture into the FIFO
	// ------------------------------------------------------------
	logic [7:0] cap_left_q;
	logic       cap_on_q, cap_wr, cap_go;
	logic       cap_wr_q;
	assign cap_go = sync_cfg_q[sync_regs_pkg::F_FIFO_FILL] && trig_edge;
	assign cap_wr = cap_on_q && sample_valid;
	// Pushing starts a cycle late, once the sample registers hold new data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cap_wr_q <= 1'b0;
		else
			cap_wr_q <= cap_wr;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_left_q <= 8'h00;
			cap_on_q   <= 1'b0;
		end else if (cap_go) begin
			cap_left_q <= sync_cnt_q;
			cap_on_q   <= 1'b1;
		end else if (cap_wr) begin
			if (cap_left_q == 8'h00)
				cap_on_q <= 1'b0;
			else
				cap_left_q <= cap_left_q - 8'h01;
		end
	end
	// ------------------------------------------------------------
	// FIFO of bytes, one word per enabled axis
	// ------------------------------------------------------------
	logic [7:0]    mem [0:FIFO_DEPTH-1];
	logic [AW-1:0] wp_q, rp_q;
	logic [sync_regs_pkg::FIFO_LEVEL_W-1:0] lvl_q, lvl_d;
	logic [1:0]    ph_q;
	logic [15:0]   ph_word;
	logic          ph_run, push, pop, full, empty, ph_en;
	logic [7:0]    last_q;
	logic          lost_q, rempty_q;
	assign full  = lvl_q == sync_regs_pkg::FIFO_LEVEL_W'(FIFO_DEPTH);
	assign empty = lvl_q == '0;
	// Byte phases: X high, X low, Z high, Z low
	assign ph_run  = ph_q != 2'b00 || cap_wr_q;
	assign ph_word = ph_q[1] ? z_q : x_q;
	assign ph_en   = ph_q[1] ? en_z : en_x;
	assign push    = ph_run && ph_en && !full;
	assign pop     = reg_rd && reg_addr == sync_regs_pkg::OFS_FIFO_PORT && !empty;
	assign lvl_d   = lvl_q + {8'h00, push} - {8'h00, pop};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ph_q <= 2'b00;
		else if (ph_run)
			ph_q <= ph_q + 2'b01;
	end
	always_ff @(posedge clk) begin
		if (push)
			mem[wp_q] <= (ph_q[0] ^ endian_swap) ? ph_word[7:0] : ph_word[15:8];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q     <= '0;
			rp_q     <= '0;
			lvl_q    <= '0;
			last_q   <= 8'h00;
			lost_q   <= 1'b0;
			rempty_q <= 1'b0;
		end else begin
			if (push)
				wp_q <= wp_q + AW'(1);
			if (pop) begin
				rp_q   <= rp_q + AW'(1);
				last_q <= mem[rp_q];
			end
			lvl_q <= lvl_d;
			if (ph_run && ph_en && full)
				lost_q <= 1'b1;
			else if (reg_rd && reg_addr == sync_regs_pkg::OFS_FIFO_FLAGS)
				lost_q <= 1'b0;
			if (reg_rd && reg_addr == sync_regs_pkg::OFS_FIFO_PORT && empty)
				rempty_q <= 1'b1;
			else if (reg_rd && reg_addr == sync_regs_pkg::OFS_FIFO_FLAGS)
				rempty_q <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Read mux and side effects
	// ------------------------------------------------------------
	logic [7:0] rd_d;
	logic [7:0] xh, xl, zh, zl, th, tl;
	assign xh = endian_swap ? x_q[7:0]  : x_q[15:8];
	assign xl = endian_swap ? x_q[15:8] : x_q[7:0];
	assign zh = endian_swap ? z_q[7:0]  : z_q[15:8];
	assign zl = endian_swap ? z_q[15:8] : z_q[7:0];
	assign th = endian_swap ? t_q[7:0]  : t_q[15:8];
	assign tl = endian_swap ? t_q[15:8] : t_q[7:0];
	always_comb begin
		rd_d = sync_regs_pkg::RST_ZERO;
		if (!reg_addr[sync_regs_pkg::COMMON_BIT]) begin
			if (bank_q == sync_regs_pkg::BANK_ZERO) begin
				case (reg_addr)
				sync_regs_pkg::OFS_POWER_CFG:  rd_d = power_cfg_q;
				sync_regs_pkg::OFS_SENSE_CFG1: rd_d = sense_cfg1_q;
				sync_regs_pkg::OFS_READY_CFG:  rd_d = ready_cfg_q;
				sync_regs_pkg::OFS_SYNC_CFG:   rd_d = sync_cfg_q;
				sync_regs_pkg::OFS_SYNC_CNT:   rd_d = sync_cnt_q;
				default:                       rd_d = sync_regs_pkg::RST_ZERO;
				endcase
			end
		end else begin
			case (reg_addr)
			sync_regs_pkg::OFS_IDENTITY:   rd_d = IDENTITY_CODE;
			sync_regs_pkg::OFS_BANK_SEL:   rd_d = {4'h0, bank_q};
			sync_regs_pkg::OFS_SYS_FLAGS:  rd_d = {6'h00, err_q, rdy_q};
			sync_regs_pkg::OFS_X_HIGH:     rd_d = xh;
			sync_regs_pkg::OFS_X_LOW:      rd_d = xl;
			sync_regs_pkg::OFS_Z_HIGH:     rd_d = zh;
			sync_regs_pkg::OFS_Z_LOW:      rd_d = zl;
			sync_regs_pkg::OFS_T_HIGH:     rd_d = th;
			sync_regs_pkg::OFS_T_LOW:      rd_d = tl;
			// Count in 16-bit words, two bytes each
			sync_regs_pkg::OFS_FIFO_LEVEL: rd_d = lvl_q[8:1];
			sync_regs_pkg::OFS_FIFO_FLAGS: rd_d = {lvl_q[8], 2'b00, lost_q,
				rempty_q, 1'b0, full, empty};
			sync_regs_pkg::OFS_FIFO_PORT:  rd_d = empty ? last_q
				: mem[rp_q];
			default:                       rd_d = sync_regs_pkg::RST_ZERO;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_d;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parity_error   <= 1'b0;
			highpass_clear <= 1'b0;
		end else begin
			if (parity_error_set)
				parity_error <= 1'b1;
			else if (wr_common && reg_addr == sync_regs_pkg::OFS_PAR_CLEAR)
				parity_error <= 1'b0;
			highpass_clear <= wr_common
				&& reg_addr == sync_regs_pkg::OFS_HP_CLEAR;
		end
	end
endmodule : sync_pin_and_common_regs

// File: sync_regs_pkg.sv
// Constants for the sync pin logic and the common register bank
package sync_regs_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] OFS_POWER_CFG  = 6'h00;
	localparam logic [5:0] OFS_SENSE_CFG1 = 6'h01;
	localparam logic [5:0] OFS_READY_CFG  = 6'h13;
	localparam logic [5:0] OFS_SYNC_CFG   = 6'h1a;
	localparam logic [5:0] OFS_SYNC_CNT   = 6'h1b;
	localparam logic [5:0] OFS_IDENTITY   = 6'h20;
	localparam logic [5:0] OFS_BANK_SEL   = 6'h21;
	localparam logic [5:0] OFS_SYS_FLAGS  = 6'h22;
	localparam logic [5:0] OFS_X_HIGH     = 6'h23;
	localparam logic [5:0] OFS_X_LOW      = 6'h24;
	localparam logic [5:0] OFS_Z_HIGH     = 6'h25;
	localparam logic [5:0] OFS_Z_LOW      = 6'h26;
	localparam logic [5:0] OFS_T_HIGH     = 6'h29;
	localparam logic [5:0] OFS_T_LOW      = 6'h2a;
	localparam logic [5:0] OFS_HP_CLEAR   = 6'h3b;
	localparam logic [5:0] OFS_FIFO_LEVEL = 6'h3c;
	localparam logic [5:0] OFS_FIFO_FLAGS = 6'h3d;
	localparam logic [5:0] OFS_FIFO_PORT  = 6'h3e;
	localparam logic [5:0] OFS_PAR_CLEAR  = 6'h3f;
	localparam int         COMMON_BIT     = 5;
	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_POWER_CFG  = 8'h07;
	localparam logic [7:0] RST_SENSE_CFG1 = 8'h28;
	localparam logic [7:0] RST_READY_CFG  = 8'h01;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [3:0] BANK_ZERO      = 4'h0;
	localparam logic [3:0] BANK_ONE       = 4'h1;
	localparam int         F_EN_X         = 0;
	localparam int         F_EN_Z         = 1;
	localparam int         F_PWR_LO       = 3;
	localparam int         F_PWR_HI       = 5;
	localparam int         F_OIS          = 0;
	localparam int         F_FIFO_FILL    = 7;
	localparam int         F_TRIG_EDGE    = 5;
	localparam int         F_POL_LOW      = 4;
	localparam int         F_RATE_MAP     = 3;
	localparam int         F_TEMP_MAP     = 2;
	localparam int         F_RDY_ON_READ  = 0;
	localparam int         F_ENDIAN       = 0;
	localparam int         FIFO_LEVEL_W   = 9;
	// ------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_DOWN, PWR_NORMAL, PWR_STANDBY, PWR_ECO
	} power_state_t;
	localparam logic [2:0] PM_DOWN     = 3'h0;
	localparam logic [2:0] PM_NORMAL   = 3'h1;
	localparam logic [2:0] PM_STANDBY  = 3'h2;
	localparam logic [2:0] PM_ECO      = 3'h3;
	localparam logic [2:0] PM_SB_ECO   = 3'h4;
	localparam logic [2:0] PM_PD_ECO   = 3'h5;
	localparam logic [2:0] PM_SB_NORM  = 3'h6;
	localparam logic [2:0] PM_PD_NORM  = 3'h7;
endpackage : sync_regs_pkg

// File: sync_host_model.sv
// Behavioural model of the party that drives the sync pin
`timescale 1ns/1ns
module sync_host_model #(
	parameter int MIN_HOLD = 63
) (
	// Clock and request
	input  wire logic clk,
	input  wire logic want_level,
	// Pin towards the device
	output logic      sync_pin
);
	int hold_q;
	initial begin
		sync_pin = 1'b0;
		hold_q = 0;
	end
	// Each level stands at least 500 ns, so short requests are delayed
	always @(posedge clk) begin
		if (hold_q != 0) begin
			hold_q <= hold_q - 1;
		end else if (want_level != sync_pin) begin
			sync_pin <= want_level;
			hold_q <= MIN_HOLD;
		end
	end
endmodule : sync_host_model

// File: sync_regs_chk.sv
// Port-level assertions for the sync pin and common register block
`timescale 1ns/1ns
module sync_regs_chk #(
	parameter logic [7:0] IDENTITY_CODE = 8'h5a
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// Register port
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	// Flags
	input wire logic       parity_error_set,
	input wire logic       parity_error,
	input wire logic       highpass_clear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	hp_pulse_a: assert property (reg_wr && reg_addr == 6'h3b |=>
		highpass_clear) else $error("highpass clear pulse missing");
	hp_cause_a: assert property (highpass_clear |-> $past(reg_wr) &&
		$past(reg_addr) == 6'h3b) else $error("stray highpass clear");
	ident_read_a: assert property (reg_rd && reg_addr == 6'h20 |=>
		reg_rdata == IDENTITY_CODE) else $error("identity mismatch");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	par_clear_a: assert property (reg_wr && reg_addr == 6'h3f &&
		!parity_error_set |=> !parity_error) else $error("parity not cleared");
	par_set_a: assert property (parity_error_set |=>
		parity_error) else $error("parity flag not set");
	par_hold_a: assert property (parity_error &&
		!(reg_wr && reg_addr == 6'h3f) |=> parity_error)
		else $error("parity flag not sticky");
	par_rise_a: assert property ($rose(parity_error) |->
		$past(parity_error_set)) else $error("parity flag without cause");
	par_zero_a: assert property (reg_rd && reg_addr == 6'h3f |=>
		reg_rdata == 8'h00) else $error("parity clear reads nonzero");
	rfu_zero_a: assert property (reg_rd && reg_addr inside
		{[6'h2b:6'h3a]} |=> reg_rdata == 8'h00) else $error("spare not zero");
	hp_cov: cover property (reg_wr && reg_addr == 6'h3b ##1 highpass_clear);
	par_cov: cover property (parity_error_set ##1 parity_error);
	id_cov: cover property (reg_rd && reg_addr == 6'h20);
endmodule : sync_regs_chk
bind sync_pin_and_common_regs sync_regs_chk #(
	.IDENTITY_CODE(IDENTITY_CODE)
) sync_regs_chk_i (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.parity_error_set(parity_error_set), .parity_error(parity_error),
	.highpass_clear(highpass_clear));

// File: sync_pin_and_common_regs_tb.sv
// Self-checking bench for the sync pin and common register block
`timescale 1ns/1ns
module sync_pin_and_common_regs_tb;
	localparam logic [7:0] ID = 8'h5a; // Arbitrary value
	logic        clk, arst_n, want_level, sync_pin;
	logic        reg_wr, reg_rd, sample_valid, endian_swap;
	logic        parity_error_set, parity_error, highpass_clear;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [15:0] rate_x, rate_z, temperature;
	logic [1:0]  power_state;
	int          error_cnt, total_checks, cycles;
	sync_pin_and_common_regs #(.IDENTITY_CODE(ID)) sync_pin_and_common_regs_i (
		.clk(clk), .arst_n(arst_n), .sync_pin(sync_pin), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid), .rate_x(rate_x),
		.rate_z(rate_z), .temperature(temperature), .endian_swap(endian_swap),
		.parity_error_set(parity_error_set), .power_state(power_state),
		.parity_error(parity_error), .highpass_clear(highpass_clear));
	sync_host_model sync_host_model_i (.clk(clk), .want_level(want_level),
		.sync_pin(sync_pin));
	// ------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ------------------------------------------------------------
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk) #1 reg_wr = 1'b0;
		@(posedge clk) #1;
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk) #1 reg_rd = 1'b0;
		chk($sformatf("register %h", a), e, reg_rdata);
		@(posedge clk) #1;
	endtask : rd
	// Sample strobes stay at least seven cycles apart so a capture burst can finish
	task automatic samp(input logic [15:0] x, z, t);
		rate_x = x;
		rate_z = z;
		temperature = t;
		sample_valid = 1'b1;
		@(posedge clk) #1 sample_valid = 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask : samp
	task automatic lvl(input logic v);
		want_level = v;
		repeat (80) @(posedge clk);
		#1;
	endtask : lvl
	task automatic pin_pwr(input logic v, input logic [1:0] e);
		int n;
		want_level = v;
		n = 0;
		while (power_state !== e && n < 100) begin
			@(posedge clk) #1;
			n++;
		end
		chk("power state", {6'h00, e}, {6'h00, power_state});
		lvl(v);
	endtask : pin_pwr
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd(6'h20, ID);
		rd(6'h21, 8'h00);
		rd(6'h00, 8'h07);
		wr(6'h21, 8'hf1);
		rd(6'h21, 8'h01);
		rd(6'h00, 8'h00);
		rd(6'h20, ID);
		wr(6'h21, 8'h00);
		rd(6'h13, 8'h01);
		rd(6'h30, 8'h00);
		rd(6'h3c, 8'h00);
		$display("register test done");
	endtask : t_regs
	task automatic t_data();
		samp(16'h1234, 16'h5678, 16'h0a0b);
		rd(6'h22, 8'h01);
		rd(6'h23, 8'h12);
		rd(6'h24, 8'h34);
		rd(6'h25, 8'h56);
		rd(6'h26, 8'h78);
		endian_swap = 1'b1;
		rd(6'h23, 8'h34);
		rd(6'h26, 8'h56);
		endian_swap = 1'b0;
		rd(6'h22, 8'h00);
		samp(16'h1111, 16'h2222, 16'h0a0b);
		samp(16'h1111, 16'h2222, 16'h0a0b);
		rd(6'h22, 8'h03);
		wr(6'h13, 8'h00);
		samp(16'h1111, 16'h2222, 16'h0a0b);
		rd(6'h24, 8'h11);
		rd(6'h22, 8'h03);
		rd(6'h22, 8'h00);
		wr(6'h13, 8'h01);
		$display("data test done");
	endtask : t_data
	task automatic t_map();
		wr(6'h1a, 8'h08);
		lvl(1'b1);
		samp(16'h1234, 16'h5678, 16'h0b0a);
		rd(6'h24, 8'h35);
		rd(6'h26, 8'h79);
		rd(6'h2a, 8'h0a);
		lvl(1'b0);
		samp(16'h1235, 16'h5678, 16'h0b0a);
		rd(6'h24, 8'h34);
		wr(6'h1a, 8'h04);
		lvl(1'b1);
		samp(16'h1234, 16'h5678, 16'h0b0a);
		rd(6'h2a, 8'h0b);
		rd(6'h24, 8'h34);
		$display("mapping test done");
	endtask : t_map
	task automatic t_power();
		logic [1:0] lo [8] = '{0, 1, 2, 3, 2, 0, 2, 0};
		logic [1:0] hi [8] = '{0, 1, 2, 3, 3, 3, 1, 1};
		wr(6'h1a, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(6'h00, {2'b00, c[2:0], 3'b111});
			pin_pwr(1'b0, lo[c]);
			pin_pwr(1'b1, hi[c]);
		end
		wr(6'h1a, 8'h10);
		pin_pwr(1'b1, 2'd0);
		pin_pwr(1'b0, 2'd1);
		wr(6'h1a, 8'h20);
		pin_pwr(1'b1, 2'd1);
		pin_pwr(1'b0, 2'd0);
		pin_pwr(1'b1, 2'd1);
		$display("power test done");
	endtask : t_power
	task automatic t_fifo();
		logic [7:0] b [8] = '{8'h11, 8'h22, 8'h33, 8'h44,
			8'h55, 8'h66, 8'h77, 8'h88};
		wr(6'h1a, 8'h80);
		wr(6'h1b, 8'h01);
		wr(6'h00, 8'h0f);
		lvl(1'b0);
		lvl(1'b1);
		samp(16'h1122, 16'h3344, 16'h0000);
		samp(16'h5566, 16'h7788, 16'h0000);
		samp(16'h99aa, 16'hbbcc, 16'h0000);
		rd(6'h3c, 8'h04);
		for (int i = 0; i < 8; i++) rd(6'h3e, b[i]);
		rd(6'h3c, 8'h00);
		rd(6'h3e, 8'h88);
		rd(6'h3d, 8'h09);
		rd(6'h3d, 8'h01);
		lvl(1'b0);
		lvl(1'b1);
		samp(16'h1122, 16'h3344, 16'h0000);
		rd(6'h3c, 8'h02);
		$display("capture test done");
	endtask : t_fifo
	task automatic t_misc();
		parity_error_set = 1'b1;
		@(posedge clk) #1 parity_error_set = 1'b0;
		chk("parity flag", 8'h01, {7'h00, parity_error});
		wr(6'h3f, 8'h55);
		chk("parity flag", 8'h00, {7'h00, parity_error});
		rd(6'h3f, 8'h00);
		reg_addr = 6'h3b;
		reg_wr = 1'b1;
		@(posedge clk) #1 reg_wr = 1'b0;
		chk("highpass clear", 8'h01, {7'h00, highpass_clear});
		@(posedge clk) #1;
		chk("highpass clear", 8'h00, {7'h00, highpass_clear});
		$display("flag test done");
	endtask : t_misc
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	initial begin
		{clk, arst_n, want_level, reg_wr, reg_rd, sample_valid} = '0;
		{endian_swap, parity_error_set, reg_addr, reg_wdata} = '0;
		{rate_x, rate_z, temperature, error_cnt, total_checks, cycles} = '0;
		repeat (16) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_regs();
		t_data();
		t_map();
		t_power();
		t_fifo();
		t_misc();
		summarize();
	end
endmodule : sync_pin_and_common_regs_tb
